// *** hdl/bct_pkg.sv ***
/*
 * Shared constants and types of the branch condition and target unit:
 * instruction field positions, branch option bits, register offsets and resets.
 * Assumes 32-bit instruction words whose least significant bit is field bit 0.
 */
package bct_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction fields, counted from bit 0 of the word.
    localparam int          OPC_HI      = 31;
    localparam int          OPC_LO      = 26;
    localparam logic [5:0]  OPC_B       = 6'h12;
    localparam logic [5:0]  OPC_BC      = 6'h10;
    localparam logic [5:0]  OPC_BIND    = 6'h13;
    localparam logic [9:0]  XO_TO_LINK  = 10'h010;
    localparam logic [9:0]  XO_TO_CTR   = 10'h210;
    localparam int          XO_HI       = 10;
    localparam int          XO_LO       = 1;
    localparam int          LDISP_HI    = 25;
    localparam int          SDISP_HI    = 15;
    localparam int          DISP_LO     = 2;
    localparam int          OPT_HI      = 25;
    localparam int          OPT_LO      = 21;
    localparam int          SEL_HI      = 20;
    localparam int          SEL_LO      = 16;
    localparam int          SIGN_S      = 15;
    localparam int          ABS_BIT     = 1;
    localparam int          LINK_BIT    = 0;

    // Branch option bits inside the 5-bit field, as indices of bo[4:0].
    localparam int          BO_NO_COND  = 4;
    localparam int          BO_COND_VAL = 3;
    localparam int          BO_NO_DEC   = 2;
    localparam int          BO_CTR_ZERO = 1;
    localparam int          BO_REVERSE  = 0;

    localparam logic [31:0] INSN_STEP   = 32'h0000_0004;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, one word each, and values after reset.
    localparam logic [7:0]  OFS_LINK    = 8'h00;
    localparam logic [7:0]  OFS_COUNT   = 8'h04;
    localparam logic [7:0]  OFS_FLAGS   = 8'h08;
    localparam logic [7:0]  OFS_STATUS  = 8'h0c;
    localparam logic [7:0]  OFS_CTRL    = 8'h10;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
    localparam logic        RST_ENABLE  = 1'b1;

    typedef enum logic [3:0] {
        BCT_NONE    = 4'b0001,
        BCT_UNCOND  = 4'b0010,
        BCT_COND    = 4'b0100,
        BCT_INDIR   = 4'b1000
    } bct_class_t;

    typedef struct packed {
        logic        valid;
        logic        taken;
        logic        predicted;
        logic        flush;
        logic [31:0] target;
        logic [31:0] redirect;
    } bct_result_t;

endpackage : bct_pkg

// *** hdl/bct_unit.sv ***
/*
 * Branch condition and target unit: decodes a branch handed over by decode,
 * resolves taken or not, forms the target, updates the link and counter
 * registers and tells fetch to flush and redirect on a wrong static guess.
 * Assumes decode presents one instruction per cycle with its address, and
 * that software reaches the link, counter and flag registers over APB.
 */
// Behaviour
// RULE1: unconditional form: 24-bit displacement with two zero bits gives signed 26 bits.
// RULE2: conditional form: 14-bit displacement with two zero bits gives signed 16 bits.
// RULE3: absolute flag clear: target is instruction address plus extended displacement.
// RULE4: relative addition wraps around the 32-bit space without fault.
// RULE5: absolute flag set: target is the extended displacement alone.
// RULE6: indirect forms take target from link register or loop counter.
// RULE7: five-bit selector picks one of 32 condition flags, numbered 0 to 31.
// RULE8: option bit 0 set ignores selector and condition flags.
// RULE9: option bit 0 clear: selected flag must equal option bit 1.
// RULE10: unconditional form always taken; its option bits are displacement.
// RULE11: option bit 2 clear decrements and tests counter; set leaves it alone.
// RULE12: option bit 3 clear needs nonzero decremented counter, set needs zero.
// RULE13: option bit 4 clear keeps static prediction, set inverts it.
// RULE14: branch taken only when every enabled test passes.
// RULE15: software writes branch-always option pattern with its z bits zero.
// RULE16: static guess taken when option bits 0 and 2 both set, or sign bit.
// RULE17: link flag loads link register with instruction address plus 4.
// RULE18: link register used as target ignores its two lowest bits.
// RULE19: counter decrement commits whether or not the branch is taken.
// RULE20: wrong guess makes fetch discard wrong path and redirect.
`timescale 1ns/10ps

module bct_unit
    import bct_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        insn_valid,
    output logic             insn_ready,
    input  wire logic [31:0] insn_word,
    input  wire logic [31:0] current_insn_addr,
    output bct_result_t      result,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decode.

    function automatic bct_class_t insn_class(input logic [31:0] w);
        logic [5:0] opc;
        logic [9:0] xo;
        opc = w[OPC_HI:OPC_LO];
        xo  = w[XO_HI:XO_LO];
        if (opc == OPC_B) begin
            return BCT_UNCOND;
        end else if (opc == OPC_BC) begin
            return BCT_COND;
        end else if (opc == OPC_BIND && (xo == XO_TO_LINK || xo == XO_TO_CTR)) begin
            return BCT_INDIR;
        end
        return BCT_NONE;
    endfunction : insn_class

    logic [31:0]  return_link_reg_r;
    logic [31:0]  loop_counter_reg_r;
    logic [31:0]  condition_flags_reg_r;
    logic         enable_r;
    logic         last_taken_r;
    logic         last_flush_r;
    logic [15:0]  branch_count_r;
    bct_result_t  result_r;
    logic [31:0]  prdata_r;

    wire bct_class_t  cls          = insn_class(insn_word);
    wire logic        fire         = insn_valid & enable_r & (cls != BCT_NONE);
    wire logic        is_uncond    = (cls == BCT_UNCOND);
    wire logic        is_cond      = (cls == BCT_COND);
    wire logic        is_indir     = (cls == BCT_INDIR);
    wire logic        to_link      = is_indir & (insn_word[XO_HI:XO_LO] == XO_TO_LINK);
    wire logic        absolute_flag = insn_word[ABS_BIT];
    wire logic        link_flag    = insn_word[LINK_BIT];
    wire logic [4:0]  branch_options = is_uncond ? 5'h14 : insn_word[OPT_HI:OPT_LO]; // RULE10
    wire logic [4:0]  cond_selector_index = insn_word[SEL_HI:SEL_LO];

    ////////////////////////////////////////////////////////////////////////////////
    // Target address.

    wire logic [23:0] long_displacement  = insn_word[LDISP_HI:DISP_LO];
    wire logic [13:0] short_displacement = insn_word[SDISP_HI:DISP_LO];
    wire logic [31:0] disp_long  = {{6{long_displacement[23]}}, long_displacement, 2'b00}; // RULE1
    wire logic [31:0] disp_short = {{16{short_displacement[13]}}, short_displacement, 2'b00}; // RULE2
    wire logic [31:0] disp_sel   = is_uncond ? disp_long : disp_short;
    // The sum is kept at 32 bits so that carries out of the top simply vanish.
    wire logic [31:0] rel_target = current_insn_addr + disp_sel; // RULE3 RULE4
    wire logic [31:0] dir_target = absolute_flag ? disp_sel : rel_target; // RULE5
    wire logic [31:0] ind_target = to_link ? {return_link_reg_r[31:2], 2'b00} // RULE6 RULE18
                                           : loop_counter_reg_r; // RULE6
    wire logic [31:0] target     = is_indir ? ind_target : dir_target;
    wire logic [31:0] next_addr  = current_insn_addr + INSN_STEP;

    ////////////////////////////////////////////////////////////////////////////////
    // Condition evaluation and static prediction.

    wire logic [31:0] ctr_dec    = loop_counter_reg_r - 32'h0000_0001;
    wire logic        flag_bit   = condition_flags_reg_r[5'h1f - cond_selector_index]; // RULE7
    wire logic        cond_ok    = branch_options[BO_NO_COND] // RULE8
                                   | (flag_bit == branch_options[BO_COND_VAL]); // RULE9
    wire logic        ctr_ok     = branch_options[BO_NO_DEC] // RULE11
                                   | ((ctr_dec == 32'h0) == branch_options[BO_CTR_ZERO]); // RULE12
    wire logic        taken      = is_uncond | (cond_ok & ctr_ok); // RULE14 RULE10
    wire logic        sign_s     = is_cond & insn_word[SIGN_S];
    wire logic        guess_def  = (branch_options[BO_NO_COND] & branch_options[BO_NO_DEC])
                                   | sign_s; // RULE16
    // Branch-always encodings are expected with the reversal bit clear.
    wire logic        predicted  = is_uncond | (guess_def ^ branch_options[BO_REVERSE]); // RULE13 RULE15
    wire logic        dec_en     = fire & ~is_uncond & ~branch_options[BO_NO_DEC];

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in the setup phase.

    wire logic        hit_link   = (paddr == OFS_LINK);
    wire logic        hit_count  = (paddr == OFS_COUNT);
    wire logic        hit_flags  = (paddr == OFS_FLAGS);
    wire logic        hit_status = (paddr == OFS_STATUS);
    wire logic        hit_ctrl   = (paddr == OFS_CTRL);
    wire logic        hit_any    = hit_link | hit_count | hit_flags | hit_status | hit_ctrl;
    wire logic        wr         = psel & penable & pwrite & hit_any;
    wire logic [31:0] rd_mux     = hit_link   ? return_link_reg_r :
                                   hit_count  ? loop_counter_reg_r :
                                   hit_flags  ? condition_flags_reg_r :
                                   hit_status ? {branch_count_r, 14'h0, last_flush_r, last_taken_r} :
                                   hit_ctrl   ? {31'h0, enable_r} : RST_WORD;

    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~hit_any;
    assign prdata     = prdata_r;
    assign insn_ready = enable_r;
    assign result     = result_r;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata_r <= RST_WORD;
        end else if (psel & ~penable & ~pwrite) begin
            prdata_r <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Branch registers. A branch update wins over a software write in the
    // same cycle, so no hardware update is ever lost.

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            return_link_reg_r <= RST_WORD;
        end else if (fire & link_flag) begin
            return_link_reg_r <= next_addr; // RULE17
        end else if (wr & hit_link) begin
            return_link_reg_r <= pwdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            loop_counter_reg_r <= RST_WORD;
        end else if (dec_en) begin
            loop_counter_reg_r <= ctr_dec; // RULE11 RULE19
        end else if (wr & hit_count) begin
            loop_counter_reg_r <= pwdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            condition_flags_reg_r <= RST_WORD;
            enable_r              <= RST_ENABLE;
        end else begin
            if (wr & hit_flags) begin
                condition_flags_reg_r <= pwdata;
            end
            if (wr & hit_ctrl) begin
                enable_r <= pwdata[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result to fetch, one cycle after the branch is accepted.

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            result_r <= '0;
        end else begin
            result_r.valid     <= fire;
            result_r.taken     <= fire & taken;
            result_r.predicted <= fire & predicted;
            result_r.flush     <= fire & (taken != predicted); // RULE20
            result_r.target    <= target;
            result_r.redirect  <= taken ? target : next_addr; // RULE20
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            last_taken_r   <= 1'b0;
            last_flush_r   <= 1'b0;
            branch_count_r <= 16'h0;
        end else if (fire) begin
            last_taken_r   <= taken;
            last_flush_r   <= (taken != predicted);
            branch_count_r <= branch_count_r + 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    chk_long_rel: assert property ( // RULE1 RULE3 RULE4
        fire && is_uncond && !absolute_flag |=> result.target ==
        $past(current_insn_addr) + {{6{$past(insn_word[25])}}, $past(insn_word[25:2]), 2'b00})
        else $error("Relative long target wrong.");
    chk_short_abs: assert property ( // RULE2 RULE5
        fire && is_cond && absolute_flag |=>
        result.target == {{16{$past(insn_word[15])}}, $past(insn_word[15:2]), 2'b00})
        else $error("Absolute short target wrong.");
    chk_link_target: assert property ( // RULE6 RULE18
        fire && to_link |=> result.target[1:0] == 2'b00 &&
        result.target[31:2] == $past(return_link_reg_r[31:2]))
        else $error("Link target wrong.");
    chk_uncond_taken: assert property ( // RULE10
        fire && is_uncond |=> result.taken && !result.flush)
        else $error("Unconditional branch not taken.");
    chk_flag_miss: assert property ( // RULE7 RULE9 RULE14
        fire && is_cond && !insn_word[25] &&
        condition_flags_reg_r[31 - insn_word[20:16]] != insn_word[24] |=> !result.taken)
        else $error("Taken despite failing flag test.");
    chk_counter_dec: assert property ( // RULE11 RULE19
        fire && !is_uncond && !insn_word[23] |=>
        loop_counter_reg_r == $past(loop_counter_reg_r) - 32'h1)
        else $error("Counter not decremented.");
    chk_counter_zero: assert property ( // RULE8 RULE12
        fire && is_cond && insn_word[25] && !insn_word[23] && insn_word[22] &&
        loop_counter_reg_r == 32'h1 |=> result.taken)
        else $error("Zero counter test failed.");
    chk_link_load: assert property ( // RULE17
        fire && link_flag |=> return_link_reg_r == $past(current_insn_addr) + 32'h4)
        else $error("Link register not loaded.");
    chk_guess: assert property ( // RULE13 RULE16
        fire && is_indir |=> result.predicted ==
        (($past(insn_word[25]) & $past(insn_word[23])) ^ $past(insn_word[21])))
        else $error("Static prediction wrong.");
    chk_flush_redir: assert property ( // RULE20
        result.valid && result.flush |-> result.taken != result.predicted &&
        result.redirect == (result.taken ? result.target : $past(current_insn_addr) + 32'h4))
        else $error("Flush without misprediction.");
    // Outcome bits only ever stand with valid, so fetch never acts on stale flags.
    chk_flush_valid: assert property ( // RULE20
        result.flush || result.taken || result.predicted |-> result.valid)
        else $error("Result flag without valid.");
    chk_fall_through: assert property ( // RULE20
        result.valid && !result.taken |-> result.redirect == $past(current_insn_addr) + 32'h4)
        else $error("Fall-through redirect wrong.");
    chk_taken_redir: assert property ( // RULE20
        result.valid && result.taken |-> result.redirect == result.target)
        else $error("Taken redirect wrong.");
    chk_refused: assert property ( // RULE14
        !(insn_valid && insn_ready) |=> !result.valid)
        else $error("Result without accepted branch.");

    ////////////////////////////////////////////////////////////////////////////////
    // Target forms not covered above.

    chk_short_rel: assert property ( // RULE2 RULE3 RULE4
        fire && is_cond && !absolute_flag |=> result.target == $past(current_insn_addr)
        + {{16{$past(insn_word[15])}}, $past(insn_word[15:2]), 2'b00})
        else $error("Relative short target wrong.");
    chk_long_abs: assert property ( // RULE1 RULE5
        fire && is_uncond && absolute_flag |=>
        result.target == {{6{$past(insn_word[25])}}, $past(insn_word[25:2]), 2'b00})
        else $error("Absolute long target wrong.");
    chk_ctr_target: assert property ( // RULE6
        fire && is_indir && !to_link |=> result.target == $past(loop_counter_reg_r))
        else $error("Counter target wrong.");

    ////////////////////////////////////////////////////////////////////////////////
    // Decision and prediction.

    chk_flag_skip: assert property ( // RULE8
        fire && is_cond && insn_word[25] && insn_word[23] |=> result.taken)
        else $error("Flags not ignored.");
    chk_cond_pass: assert property ( // RULE9 RULE14
        fire && is_cond && !insn_word[25] && insn_word[23] &&
        condition_flags_reg_r[31 - insn_word[20:16]] == insn_word[24] |=> result.taken)
        else $error("Branch not taken on passing flag test.");
    chk_counter_fail: assert property ( // RULE12 RULE14
        fire && is_cond && !insn_word[23] && (loop_counter_reg_r == 32'h1) != insn_word[22]
        |=> !result.taken)
        else $error("Taken despite failing counter test.");
    chk_guess_cond: assert property ( // RULE13 RULE16
        fire && is_cond |=> result.predicted ==
        ((($past(insn_word[25]) & $past(insn_word[23])) | $past(insn_word[15]))
         ^ $past(insn_word[21])))
        else $error("Conditional prediction wrong.");
    chk_uncond_guess: assert property ( // RULE10
        fire && is_uncond |=> result.predicted)
        else $error("Unconditional branch not predicted taken.");

    ////////////////////////////////////////////////////////////////////////////////
    // Register side. A branch update wins over a write in the same cycle, so the
    // write checks leave that case out.

    chk_counter_hold: assert property ( // RULE11
        fire && (is_uncond || insn_word[23]) && !(wr && hit_count) |=>
        $stable(loop_counter_reg_r))
        else $error("Counter changed without decrement.");
    chk_link_hold: assert property ( // RULE17
        fire && !link_flag && !(wr && hit_link) |=> $stable(return_link_reg_r))
        else $error("Link register changed without link flag.");
    chk_count_write: assert property (
        wr && hit_count && !dec_en |=> loop_counter_reg_r == $past(pwdata))
        else $error("Counter write lost.");
    chk_link_write: assert property (
        wr && hit_link && !(fire && link_flag) |=> return_link_reg_r == $past(pwdata))
        else $error("Link write lost.");
    chk_flags_write: assert property ( // RULE7
        wr && hit_flags |=> condition_flags_reg_r == $past(pwdata))
        else $error("Flag write lost.");
    chk_ctrl_write: assert property (
        wr && hit_ctrl |=> enable_r == $past(pwdata[0]))
        else $error("Enable write lost.");
    chk_status_count: assert property (
        fire |=> branch_count_r == $past(branch_count_r) + 16'h1)
        else $error("Branch count not advanced.");

    cov_loop_back:  cover property (fire && is_cond && !insn_word[23] ##1 result.taken);
    cov_mispredict: cover property (result.valid && result.flush);
    cov_link_ret:   cover property (fire && link_flag ##1 fire && to_link);
    cov_reg_write:  cover property (wr && hit_count ##2 fire);
    cov_abs_target: cover property (fire && absolute_flag);

endmodule : bct_unit

// *** bench/bct_fetch_model.sv ***
/*
 * Fetch side partner of the branch unit: follows the redirect on every flush.
 * Assumes the result bus is registered and pulses valid for one cycle.
 */
`timescale 1ns/10ps

module bct_fetch_model
    import bct_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire bct_result_t result,
    output logic [31:0]      fetch_pc,
    output logic [7:0]       flush_cnt
);
    ////////////////////////////////////////////////////////////////////////////////
    // Wrong-path work is dropped by jumping to the resolved address.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fetch_pc  <= 32'h0000_0000;
            flush_cnt <= 8'h00;
        end else if (result.valid && result.flush) begin
            fetch_pc  <= result.redirect;
            flush_cnt <= flush_cnt + 8'h01;
        end
    end
endmodule : bct_fetch_model

// *** bench/branch_condition_target_unit_tb.sv ***
/*
 * Self-checking bench of the branch unit: APB set-up, one branch, compare.
 * Assumes pready may come late and results land one edge after acceptance.
 */
`timescale 1ns/10ps

module branch_condition_target_unit_tb
    import bct_pkg::*;
;
    logic        core_clk, sys_rst, insn_valid, insn_ready;
    logic [31:0] insn_word, current_insn_addr, pwdata, prdata, rv, fetch_pc;
    logic        psel, penable, pwrite, pready, pslverr, e_err;
    logic [7:0]  paddr, flush_cnt, e_fl;
    bct_result_t result;
    int          n_fail, n_tests;

    bct_unit bct_unit_inst (.core_clk(core_clk), .sys_rst(sys_rst), .insn_valid(insn_valid),
        .insn_ready(insn_ready), .insn_word(insn_word), .current_insn_addr(current_insn_addr),
        .result(result), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    bct_fetch_model bct_fetch_model_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .result(result), .fetch_pc(fetch_pc), .flush_cnt(flush_cnt));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask : chk

    // The slave may stretch the access phase, so the wait is open ended.
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rv      = prdata;
        e_err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic issue(input logic [31:0] w, input logic [31:0] a);
        @(posedge core_clk);
        insn_valid        <= 1'b1;
        insn_word         <= w;
        current_insn_addr <= a;
        @(posedge core_clk);
        insn_valid        <= 1'b0;
        #1;
    endtask : issue

    task automatic run(input logic [31:0] w, a, l, c, f);
        logic [4:0]  bo;
        logic [31:0] dc, tg;
        logic        tk, pd, br;
        apb(1'b1, OFS_LINK, l);
        apb(1'b1, OFS_COUNT, c);
        apb(1'b1, OFS_FLAGS, f);
        bo = w[25:21];
        dc = c - 32'h1;
        br = (w[31:26] == OPC_B);
        tk = br | ((bo[4] | (f[5'd31 - w[20:16]] == bo[3])) & (bo[2] | ((dc == 0) == bo[1])));
        pd = br | (((bo[4] & bo[2]) | (w[15] & (w[31:26] == OPC_BC))) ^ bo[0]);
        if (br) tg = {{6{w[25]}}, w[25:2], 2'b00};
        else tg = {{16{w[15]}}, w[15:2], 2'b00};
        if (!w[1]) tg = tg + a;
        if (w[31:26] == OPC_BIND) tg = (w[10:1] == XO_TO_LINK) ? {l[31:2], 2'b00} : c;
        issue(w, a);
        chk("valid", 32'h1, 32'(result.valid));
        chk("taken", 32'(tk), 32'(result.taken));
        chk("guess", 32'(pd), 32'(result.predicted));
        chk("flush", 32'(tk ^ pd), 32'(result.flush));
        chk("target", tg, result.target);
        chk("redir", tk ? tg : a + INSN_STEP, result.redirect);
        e_fl = e_fl + 8'(tk ^ pd);
        apb(1'b0, OFS_LINK, 32'h0);
        chk("link", w[0] ? a + INSN_STEP : l, rv);
        apb(1'b0, OFS_COUNT, 32'h0);
        chk("count", (br | bo[2]) ? c : dc, rv);
        if (tk ^ pd) chk("fpc", tk ? tg : a + INSN_STEP, fetch_pc);
        $display("test %h done", w);
    endtask : run

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        #100000;
        n_fail++;
        stop_test();
    end

    // Option patterns keep every mandatory zero position at zero.
    initial begin
        {sys_rst, insn_valid, insn_word, current_insn_addr} = {1'b1, 65'h0};
        {psel, penable, pwrite, paddr, pwdata, n_fail, n_tests, e_fl} = '0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset", (i == 4) ? 32'(RST_ENABLE) : RST_WORD, rv);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("perr", 32'h1, 32'(e_err));
        chk("pdata", 32'h0, rv);
        issue(32'h7c00_0000, 32'h100);
        chk("refuse", 32'h0, 32'(result.valid));
        run({OPC_B, 24'h000010, 2'b01}, 32'h1000, 0, 0, 0);
        run({OPC_B, 24'hfffff0, 2'b00}, 32'h8, 0, 0, 0);
        run({OPC_B, 24'h800000, 2'b10}, 32'h1000, 0, 0, 0);
        run({OPC_BC, 5'b10100, 5'h00, 14'h0008, 2'b00}, 32'hffff_fff0, 0, 5, 0);
        run({OPC_BC, 5'b00100, 5'h1f, 14'h0010, 2'b00}, 32'h100, 0, 0, 32'hffff_fffe);
        run({OPC_BC, 5'b01101, 5'h00, 14'h0010, 2'b01}, 32'h200, 0, 0, 32'h8000_0000);
        run({OPC_BC, 5'b00000, 5'h05, 14'h3ff0, 2'b00}, 32'h300, 0, 2, 32'h0400_0000);
        run({OPC_BC, 5'b10010, 5'h00, 14'h0100, 2'b10}, 32'h400, 0, 1, 32'hffff_ffff);
        run({OPC_BC, 5'b10000, 5'h00, 14'h0100, 2'b00}, 32'h500, 0, 1, 0);
        run({OPC_BC, 5'b01010, 5'h03, 14'h0040, 2'b00}, 32'h600, 0, 1, 32'h1000_0000);
        run({OPC_BIND, 5'b10100, 10'h0, XO_TO_LINK, 1'b1}, 32'h700, 32'h2003, 0, 0);
        run({OPC_BIND, 5'b01100, 5'h01, 5'h0, XO_TO_CTR, 1'b0}, 32'h800, 0, 32'h3000, 0);
        run({OPC_BIND, 5'b10000, 10'h0, XO_TO_CTR, 1'b0}, 32'h900, 0, 32'h4000, 0);
        apb(1'b1, OFS_CTRL, 32'h0);
        #1;
        chk("ready", 32'h0, 32'(insn_ready));
        issue({OPC_BC, 5'b10100, 5'h00, 14'h0008, 2'b00}, 32'h100);
        chk("off", 32'h0, 32'(result.valid));
        chk("fetch", 32'(e_fl), 32'(flush_cnt));
        stop_test();
    end
endmodule : branch_condition_target_unit_tb
